// >>> shared/flash_seq_pkg.sv
// Constants and types shared by the flash write sequencer design
package flash_seq_pkg;

  // Register offsets in the control register space
  localparam logic [23:0] ADDR_CTRL_LOW   = 24'h0E0000;
  localparam logic [23:0] ADDR_CTRL_HIGH  = 24'h0E0002;
  localparam logic [23:0] ADDR_SECT_LOW   = 24'h0E0004;
  localparam logic [23:0] ADDR_SECT_HIGH  = 24'h0E0006;
  localparam logic [23:0] ADDR_DATA0_LOW  = 24'h0E0008;
  localparam logic [23:0] ADDR_DATA0_HIGH = 24'h0E000A;
  localparam logic [23:0] ADDR_DATA1_LOW  = 24'h0E000C;
  localparam logic [23:0] ADDR_DATA1_HIGH = 24'h0E000E;
  localparam logic [23:0] ADDR_TGT_LOW    = 24'h0E0010;
  localparam logic [23:0] ADDR_TGT_HIGH   = 24'h0E0012;
  localparam logic [23:0] ADDR_ERR        = 24'h0E0014;

  // Status register bit positions
  localparam int BIT_BANK1_BUSY = 6;
  localparam int BIT_BANK0_BUSY = 5;
  localparam int BIT_LOCK       = 4;

  // Operation register bit positions
  localparam int BIT_WRITE_START = 15;
  localparam int BIT_SUSPEND     = 14;
  localparam int BIT_WORD_PROG   = 13;
  localparam int BIT_DWORD_PROG  = 12;
  localparam int BIT_ERASE       = 11;
  localparam int BIT_PROTECT     = 8;
  localparam int BIT_SPECIAL     = 0;

  // Error register bit positions
  localparam int BIT_ERR_ANY = 0;
  localparam int BIT_ERR_SEQ = 1;

  // Sector select widths
  localparam int BANK0_SECTORS = 10;
  localparam int ALL_SECTORS   = 12;

  // Write-mode address map
  localparam logic [23:0] TEST_SECTOR_TOP = 24'h001FFF;
  localparam logic [23:0] BANK1_BASE      = 24'h060000;
  localparam logic [23:0] FLASH_TOP       = 24'h07FFFF;
  localparam logic [23:0] PROT_LOW        = 24'h0EDFB0;
  localparam logic [23:0] PROT_HIGH       = 24'h0EDFBF;

  // Values after reset and fixed answers
  localparam logic [15:0] RESET_VALUE  = 16'h0000;
  localparam logic [15:0] INVALID_DATA = 16'hFFFF;
  localparam logic [15:0] TRAP_CODE    = 16'h009B;
  localparam logic [31:0] ERASED_WORD  = 32'hFFFFFFFF;
  localparam logic [31:0] PREPROG_WORD = 32'h00000000;

  typedef enum logic [2:0] {OP_NONE, OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} op_kind_type;
  typedef enum logic [1:0] {ARR_READ, ARR_PROG, ARR_PREPROG, ARR_ERASE} arr_cmd_type;

endpackage : flash_seq_pkg

// >>> shared/op_if.sv
// Operation hand-off between register front end and array engine
`timescale 1ns/1ps
`default_nettype none
interface op_if;
  import flash_seq_pkg::*;
  logic        start;
  op_kind_type kind;
  logic [23:0] addr;
  logic [31:0] data0;
  logic [31:0] data1;
  logic [11:0] sectors;
  logic        hold;
  logic        done;

  modport front (output start, kind, addr, data0, data1, sectors, hold, input done);
  modport engine (input start, kind, addr, data0, data1, sectors, hold, output done);
endinterface : op_if
`default_nettype wire

// >>> hdl/op_engine.sv
// Array sequencing engine for program and erase operations
`timescale 1ns/1ps
`default_nettype none
module op_engine
  import flash_seq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  op_if.engine             op,
  output logic             arr_req,
  output arr_cmd_type      arr_cmd,
  output logic [23:0]      arr_addr,
  output logic [3:0]       arr_sector,
  output logic [31:0]      arr_wdata,
  input  wire logic [31:0] arr_rdata,
  input  wire logic        arr_ack
);

  typedef enum logic [2:0] {S_IDLE, S_READ, S_PROG, S_SCAN, S_PRE, S_ERASE, S_FIN} eng_state_type;

  eng_state_type state_reg, state_next;
  op_kind_type   kind_reg, kind_next;
  logic [23:0]   addr_reg, addr_next;
  logic [31:0]   d0_reg, d0_next, d1_reg, d1_next, old_reg, old_next;
  logic [11:0]   sect_reg, sect_next;
  logic [3:0]    sidx_reg, sidx_next;
  logic          word_reg, word_next;

  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    addr_next  = addr_reg;
    d0_next    = d0_reg;
    d1_next    = d1_reg;
    old_next   = old_reg;
    sect_next  = sect_reg;
    sidx_next  = sidx_reg;
    word_next  = word_reg;
    case (state_reg)
      S_IDLE: begin
        if (op.start) begin
          kind_next  = op.kind;
          addr_next  = op.addr;
          d0_next    = op.data0;
          d1_next    = op.data1;
          sect_next  = op.sectors;
          sidx_next  = 4'h0;
          word_next  = 1'b0;
          state_next = (op.kind == OP_ERASE) ? S_SCAN : S_READ;
        end
      end
      S_READ: begin
        if (arr_ack) begin
          old_next   = arr_rdata;
          state_next = S_PROG;
        end
      end
      S_PROG: begin
        if (arr_ack) begin
          if (kind_reg == OP_DWORD && !word_reg) begin
            word_next  = 1'b1;
            state_next = S_READ;
          end else begin
            state_next = S_FIN;
          end
        end
      end
      S_SCAN: begin
        if (sidx_reg == 4'(ALL_SECTORS)) begin
          state_next = S_FIN;
        end else if (sect_reg[sidx_reg]) begin
          state_next = S_PRE;
        end else begin
          sidx_next = sidx_reg + 4'h1;
        end
      end
      S_PRE: begin
        if (arr_ack) begin
          state_next = S_ERASE;
        end
      end
      S_ERASE: begin
        if (arr_ack) begin
          sidx_next  = sidx_reg + 4'h1;
          state_next = S_SCAN;
        end
      end
      S_FIN: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      kind_reg  <= OP_NONE;
      addr_reg  <= 24'h000000;
      d0_reg    <= 32'h00000000;
      d1_reg    <= 32'h00000000;
      old_reg   <= 32'h00000000;
      sect_reg  <= 12'h000;
      sidx_reg  <= 4'h0;
      word_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      addr_reg  <= addr_next;
      d0_reg    <= d0_next;
      d1_reg    <= d1_next;
      old_reg   <= old_next;
      sect_reg  <= sect_next;
      sidx_reg  <= sidx_next;
      word_reg  <= word_next;
    end
  end

  assign arr_req = !op.hold && (state_reg == S_READ || state_reg == S_PROG
                               || state_reg == S_PRE || state_reg == S_ERASE);
  assign arr_cmd = (state_reg == S_PROG)  ? ARR_PROG :
                   (state_reg == S_PRE)   ? ARR_PREPROG :
                   (state_reg == S_ERASE) ? ARR_ERASE : ARR_READ;
  assign arr_addr   = {addr_reg[23:3], addr_reg[2] | word_reg, addr_reg[1:0]};
  assign arr_sector = sidx_reg;
  assign arr_wdata  = (state_reg == S_PRE) ? PREPROG_WORD :
                      (old_reg & (word_reg ? d1_reg : d0_reg));
  assign op.done    = (state_reg == S_FIN);

endmodule : op_engine
`default_nettype wire

// >>> hdl/flash_write_control_sequencer.sv
// Register front end and status logic of the flash program/erase controller
`timescale 1ns/1ps
`default_nettype none
module flash_write_control_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [23:0] reg_addr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_trap,
  input  wire logic [1:0]  bank_rd,
  input  wire logic [1:0]  bank_wr,
  output logic [1:0]       bank_rd_trap,
  output logic [1:0]       bank_wr_allow,
  input  wire logic        bootstrap_mode,
  input  wire logic        test_sector_wr,
  output logic             test_sector_visible,
  output logic             test_write_deny,
  output logic             arr_req,
  output arr_cmd_type      arr_cmd,
  output logic [23:0]      arr_addr,
  output logic [3:0]       arr_sector,
  output logic [31:0]      arr_wdata,
  input  wire logic [31:0] arr_rdata,
  input  wire logic        arr_ack
);

  op_if opi ();

  logic [1:0]  busy_reg, busy_next, opbank_reg, opbank_next;
  logic        lock_reg, lock_next, wms_reg, wms_next, suspend_bit_reg, suspend_bit_next;
  logic        wpg_reg, wpg_next, double_word_program_select_reg, double_word_program_select_next, ser_reg, ser_next;
  logic        spr_reg, spr_next, special_mode_bit_reg, special_mode_bit_next, paused_reg, paused_next;
  logic [11:0] sect_reg, sect_next;
  logic [31:0] data0_reg, data0_next, data1_reg, data1_next;
  logic [23:0] tgt_reg, tgt_next;
  logic [1:0]  fer_reg, fer_next, pend_reg, pend_next;
  op_kind_type kind_reg, kind_next;
  logic        start_reg, start_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        trap_reg, trap_next, tdeny_reg, tdeny_next, tvis_reg;
  logic [1:0]  brd_reg, brd_next;

  logic        wr_hit_high, start_req, seq_err, tgt_in_bank1, tgt_in_test;
  logic [15:0] wr_merged, high_now, high_new;
  op_kind_type new_kind;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  always_comb begin
    high_now = 16'h0000;
    high_now[BIT_WRITE_START] = wms_reg;
    high_now[BIT_SUSPEND]     = suspend_bit_reg;
    high_now[BIT_WORD_PROG]   = wpg_reg;
    high_now[BIT_DWORD_PROG]  = double_word_program_select_reg;
    high_now[BIT_ERASE]       = ser_reg;
    high_now[BIT_PROTECT]     = spr_reg;
    high_now[BIT_SPECIAL]     = special_mode_bit_reg;
  end

  assign wr_merged    = merge16(high_now, reg_wdata, reg_be);
  assign wr_hit_high  = reg_wr && reg_addr == ADDR_CTRL_HIGH;
  assign high_new     = wr_merged;
  assign tgt_in_bank1 = tgt_reg >= BANK1_BASE;
  assign tgt_in_test  = tgt_reg <= TEST_SECTOR_TOP;

  // start refused on error or suspend
  assign start_req = wr_hit_high && !lock_reg && high_new[BIT_WRITE_START] && !wms_reg
                     && !fer_reg[BIT_ERR_ANY] && !suspend_bit_reg && !high_new[BIT_SUSPEND];

  always_comb begin
    if (high_new[BIT_PROTECT]) begin
      new_kind = OP_PROT;
    end else if (high_new[BIT_ERASE]) begin
      new_kind = OP_ERASE;
    end else if (high_new[BIT_DWORD_PROG]) begin
      new_kind = OP_DWORD;
    end else if (high_new[BIT_WORD_PROG]) begin
      new_kind = OP_WORD;
    end else begin
      new_kind = OP_NONE;
    end
    seq_err = 1'b0;
    case (new_kind)
      OP_PROT: seq_err = tgt_reg < PROT_LOW || tgt_reg > PROT_HIGH;
      OP_ERASE: seq_err = !high_new[BIT_SPECIAL] || sect_reg == 12'h000
                          || (|sect_reg[ALL_SECTORS-1:BANK0_SECTORS]
                              && |sect_reg[BANK0_SECTORS-1:0]);
      OP_DWORD: seq_err = !high_new[BIT_SPECIAL] || tgt_reg[2:0] != 3'b000
                          || tgt_in_test || tgt_reg > FLASH_TOP;
      OP_WORD: seq_err = !high_new[BIT_SPECIAL] || tgt_reg[1:0] != 2'b00
                         || tgt_in_test || tgt_reg > FLASH_TOP;
      default: seq_err = !paused_reg;
    endcase
  end

  always_comb begin
    busy_next   = busy_reg;
    opbank_next = opbank_reg;
    lock_next   = lock_reg;
    wms_next    = wms_reg;
    suspend_bit_next   = suspend_bit_reg;
    wpg_next    = wpg_reg;
    double_word_program_select_next   = double_word_program_select_reg;
    ser_next    = ser_reg;
    spr_next    = spr_reg;
    special_mode_bit_next   = special_mode_bit_reg;
    paused_next = paused_reg;
    sect_next   = sect_reg;
    data0_next  = data0_reg;
    data1_next  = data1_reg;
    tgt_next    = tgt_reg;
    fer_next    = fer_reg;
    pend_next   = pend_reg;
    kind_next   = kind_reg;
    start_next  = 1'b0;
    tdeny_next  = 1'b0;
    if (reg_wr && !lock_reg) begin
      case (reg_addr)
        ADDR_CTRL_HIGH: begin
          suspend_bit_next = high_new[BIT_SUSPEND];
          wpg_next  = high_new[BIT_WORD_PROG];
          double_word_program_select_next = high_new[BIT_DWORD_PROG];
          ser_next  = high_new[BIT_ERASE];
          spr_next  = high_new[BIT_PROTECT];
          special_mode_bit_next = high_new[BIT_SPECIAL];
        end
        ADDR_SECT_LOW: sect_next[BANK0_SECTORS-1:0] =
          BANK0_SECTORS'(merge16({6'h00, sect_reg[BANK0_SECTORS-1:0]}, reg_wdata, reg_be));
        ADDR_SECT_HIGH: sect_next[ALL_SECTORS-1:BANK0_SECTORS] =
          2'(merge16({14'h0000, sect_reg[ALL_SECTORS-1:BANK0_SECTORS]}, reg_wdata, reg_be));
        ADDR_DATA0_LOW:  data0_next[15:0]  = merge16(data0_reg[15:0], reg_wdata, reg_be);
        ADDR_DATA0_HIGH: data0_next[31:16] = merge16(data0_reg[31:16], reg_wdata, reg_be);
        ADDR_DATA1_LOW:  data1_next[15:0]  = merge16(data1_reg[15:0], reg_wdata, reg_be);
        ADDR_DATA1_HIGH: data1_next[31:16] = merge16(data1_reg[31:16], reg_wdata, reg_be);
        ADDR_TGT_LOW:    tgt_next[15:0]    = merge16(tgt_reg[15:0], reg_wdata, reg_be);
        ADDR_TGT_HIGH:   tgt_next[23:16]   = 8'(merge16({8'h00, tgt_reg[23:16]}, reg_wdata,
                                                        reg_be));
        ADDR_ERR: fer_next = 2'(merge16({14'h0000, fer_reg}, reg_wdata, reg_be));
        default: ;
      endcase
    end
    if (wr_hit_high && wms_reg && high_new[BIT_SUSPEND]) begin
      suspend_bit_next   = 1'b1;
      paused_next = 1'b1;
      wms_next    = 1'b0;
      lock_next   = 1'b0;
      busy_next   = 2'b00;
    end
    if (start_req) begin
      if (paused_reg) begin
        paused_next = 1'b0;
        wms_next    = 1'b1;
        lock_next   = 1'b1;
        busy_next   = opbank_reg;
      end else if (seq_err) begin
        pend_next[BIT_ERR_ANY] = 1'b1;
        pend_next[BIT_ERR_SEQ] = 1'b1;
        tdeny_next = (new_kind == OP_WORD || new_kind == OP_DWORD) && tgt_in_test;
      end else begin
        wms_next   = 1'b1;
        lock_next  = 1'b1;
        start_next = 1'b1;
        kind_next  = new_kind;
        case (new_kind)
          OP_PROT:  opbank_next = 2'b11;
          OP_ERASE: opbank_next = (|sect_reg[ALL_SECTORS-1:BANK0_SECTORS]) ? 2'b10 : 2'b01;
          default:  opbank_next = tgt_in_bank1 ? 2'b10 : 2'b01;
        endcase
        busy_next = opbank_next;
      end
    end
    if (opi.done) begin
      wms_next    = 1'b0;
      paused_next = 1'b0;
      lock_next   = 1'b0;
      busy_next = 2'b00;
      special_mode_bit_next = 1'b0;
      case (kind_reg)
        OP_WORD:  wpg_next  = 1'b0;
        OP_DWORD: double_word_program_select_next = 1'b0;
        OP_ERASE: begin
          ser_next  = 1'b0;
          sect_next = 12'h000;
        end
        OP_PROT:  spr_next  = 1'b0;
        default: ;
      endcase
    end
    if (busy_reg == 2'b00 && pend_reg != 2'b00) begin
      fer_next  = fer_next | pend_reg;
      pend_next = pend_next & ~pend_reg;
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    trap_next  = 1'b0;
    if (reg_rd) begin
      if (lock_reg && reg_addr != ADDR_CTRL_LOW) begin
        rdata_next = INVALID_DATA;
        trap_next  = reg_addr >= ADDR_CTRL_LOW && reg_addr <= ADDR_ERR;
      end else begin
        case (reg_addr)
          ADDR_CTRL_LOW: begin
            rdata_next[BIT_BANK1_BUSY] = busy_reg[1];
            rdata_next[BIT_BANK0_BUSY] = busy_reg[0];
            rdata_next[BIT_LOCK]       = lock_reg;
          end
          ADDR_CTRL_HIGH:  rdata_next = high_now;
          ADDR_SECT_LOW:   rdata_next = {6'h00, sect_reg[BANK0_SECTORS-1:0]};
          ADDR_SECT_HIGH:  rdata_next = {14'h0000, sect_reg[ALL_SECTORS-1:BANK0_SECTORS]};
          ADDR_DATA0_LOW:  rdata_next = data0_reg[15:0];
          ADDR_DATA0_HIGH: rdata_next = data0_reg[31:16];
          ADDR_DATA1_LOW:  rdata_next = data1_reg[15:0];
          ADDR_DATA1_HIGH: rdata_next = data1_reg[31:16];
          ADDR_TGT_LOW:    rdata_next = tgt_reg[15:0];
          ADDR_TGT_HIGH:   rdata_next = {8'h00, tgt_reg[23:16]};
          ADDR_ERR:        rdata_next = {14'h0000, fer_reg};
          default:         rdata_next = 16'h0000;
        endcase
      end
    end
    brd_next = bank_rd & busy_reg;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg   <= 2'b00;
      opbank_reg <= 2'b00;
      lock_reg   <= 1'b0;
      wms_reg    <= 1'b0;
      suspend_bit_reg   <= 1'b0;
      wpg_reg    <= 1'b0;
      double_word_program_select_reg   <= 1'b0;
      ser_reg    <= 1'b0;
      spr_reg    <= 1'b0;
      special_mode_bit_reg   <= 1'b0;
      paused_reg <= 1'b0;
      sect_reg   <= 12'h000;
      data0_reg  <= 32'h00000000;
      data1_reg  <= 32'h00000000;
      tgt_reg    <= 24'h000000;
      fer_reg    <= 2'b00;
      pend_reg   <= 2'b00;
      kind_reg   <= OP_NONE;
      start_reg  <= 1'b0;
      rdata_reg  <= RESET_VALUE;
      trap_reg   <= 1'b0;
      tdeny_reg  <= 1'b0;
      tvis_reg   <= 1'b0;
      brd_reg    <= 2'b00;
    end else begin
      busy_reg   <= busy_next;
      opbank_reg <= opbank_next;
      lock_reg   <= lock_next;
      wms_reg    <= wms_next;
      suspend_bit_reg   <= suspend_bit_next;
      wpg_reg    <= wpg_next;
      double_word_program_select_reg   <= double_word_program_select_next;
      ser_reg    <= ser_next;
      spr_reg    <= spr_next;
      special_mode_bit_reg   <= special_mode_bit_next;
      paused_reg <= paused_next;
      sect_reg   <= sect_next;
      data0_reg  <= data0_next;
      data1_reg  <= data1_next;
      tgt_reg    <= tgt_next;
      fer_reg    <= fer_next;
      pend_reg   <= pend_next;
      kind_reg   <= kind_next;
      start_reg  <= start_next;
      rdata_reg  <= rdata_next;
      trap_reg   <= trap_next;
      tdeny_reg  <= tdeny_next;
      tvis_reg   <= bootstrap_mode;
      brd_reg    <= brd_next;
    end
  end

  assign opi.start   = start_reg;
  assign opi.kind    = kind_reg;
  assign opi.addr    = tgt_reg;
  assign opi.data0   = data0_reg;
  assign opi.data1   = data1_reg;
  assign opi.sectors = sect_reg;
  assign opi.hold    = paused_reg;

  op_engine u_engine (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .op         (opi.engine),
    .arr_req    (arr_req),
    .arr_cmd    (arr_cmd),
    .arr_addr   (arr_addr),
    .arr_sector (arr_sector),
    .arr_wdata  (arr_wdata),
    .arr_rdata  (arr_rdata),
    .arr_ack    (arr_ack)
  );

  assign reg_rdata           = rdata_reg;
  assign reg_trap            = trap_reg;
  assign bank_rd_trap        = brd_reg;
  // busy banks, and the test sector outside bootstrap mode, refuse writes
  assign bank_wr_allow       = bank_wr & ~busy_reg & {1'b1, !(test_sector_wr && !bootstrap_mode)};
  assign test_sector_visible = tvis_reg;
  assign test_write_deny     = tdeny_reg | (test_sector_wr && bank_wr[0] && !bootstrap_mode);

endmodule : flash_write_control_sequencer
`default_nettype wire

// >>> dv/flash_array_model.sv
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arr_req,
  input  wire arr_cmd_type arr_cmd,
  input  wire logic [23:0] arr_addr,
  input  wire logic [3:0]  arr_sector,
  input  wire logic [31:0] arr_wdata,
  input  wire logic        slow,
  output logic [31:0]      arr_rdata,
  output logic             arr_ack
);
  logic [31:0] mem [int];
  int          hold = 0;
  initial arr_ack = 1'b0;
  initial arr_rdata = 32'h0;
  always @(posedge ref_clk) begin
    arr_ack <= 1'b0;
    arr_rdata <= ~arr_rdata;
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (arr_req && !arr_ack) begin
      arr_ack <= 1'b1;
      hold <= slow ? 20 : int'($urandom_range(2));
      if (arr_cmd == ARR_READ) begin
        arr_rdata <= mem.exists(arr_addr) ? mem[arr_addr] : ERASED_WORD;
      end else if (arr_cmd == ARR_PROG) begin
        mem[arr_addr] = arr_wdata;
      end else begin
        foreach (mem[k]) begin
          if (k[23:16] == 8'h06 + 8'(arr_sector) - 8'h0A) begin
            mem[k] = (arr_cmd == ARR_ERASE) ? ERASED_WORD : arr_wdata;
          end
        end
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// >>> dv/flash_seq_asserts.sv
// Port checks of the flash write sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_seq_asserts
  import flash_seq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        reg_rd,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_trap,
  input wire logic [1:0]  bank_rd,
  input wire logic [1:0]  bank_rd_trap,
  input wire logic [1:0]  bank_wr,
  input wire logic [1:0]  bank_wr_allow,
  input wire logic        bootstrap_mode,
  input wire logic        test_sector_wr,
  input wire logic        test_write_deny,
  input wire logic        test_sector_visible,
  input wire logic        arr_req,
  input wire arr_cmd_type arr_cmd,
  input wire logic [23:0] arr_addr,
  input wire logic [31:0] arr_wdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_TRAP_DATA: assert property (reg_trap
    |-> $past(reg_rd) && reg_rdata == INVALID_DATA) else $error("bad trap");
  AST_STATUS_OPEN: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CTRL_LOW
    |-> !reg_trap && (reg_rdata & 16'hFF8F) == 16'h0000) else $error("bad status");
  AST_BUSY_LOCK: assert property (arr_req && reg_rd && reg_addr == ADDR_CTRL_LOW
    |=> reg_rdata[BIT_LOCK] && reg_rdata[6:5] != 2'h0) else $error("no busy");
  AST_TRAP_CAUSE: assert property ((bank_rd_trap & ~$past(bank_rd)) == 2'h0)
    else $error("stray trap");
  AST_BANK1_TRAP: assert property (arr_req && arr_cmd == ARR_PROG && bank_rd[1]
    && arr_addr >= BANK1_BASE |=> bank_rd_trap[1]) else $error("no bank trap");
  AST_WR_ALLOW: assert property ((bank_wr_allow & ~bank_wr) == 2'h0)
    else $error("bad allow");
  AST_TEST_DENY: assert property (bank_wr[0] && test_sector_wr && !bootstrap_mode
    |-> !bank_wr_allow[0] && test_write_deny) else $error("test write");
  AST_PREPROG_ZERO: assert property (arr_req && arr_cmd == ARR_PREPROG
    |-> arr_wdata == PREPROG_WORD) else $error("bad preprog");
  AST_TEST_VISIBLE: assert property (test_sector_visible == $past(bootstrap_mode))
    else $error("bad visibility");
  AST_BUSY_WR_BLOCK: assert property (arr_req && arr_cmd inside {ARR_READ, ARR_PROG}
    |-> (bank_wr_allow & ((arr_addr >= BANK1_BASE) ? 2'b10 : 2'b01)) == 2'h0)
    else $error("busy bank write");
endmodule : flash_seq_asserts
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the flash write sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import flash_seq_pkg::*;
;
  logic        ref_clk = 1'b0, nrst = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0, slow = 1'b0;
  logic        reg_trap, arr_req, arr_ack, bootstrap_mode = 1'b0, test_sector_wr = 1'b0;
  logic [23:0] reg_addr = 24'h000000, arr_addr, a, b;
  logic [1:0]  bank_rd = 2'h0, bank_wr = 2'h0, bank_rd_trap, bank_wr_allow;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [31:0] arr_wdata, arr_rdata, d, e;
  logic [16:0] rv;
  logic [3:0]  arr_sector;
  arr_cmd_type arr_cmd;
  int          failures = 0, cmp_count = 0, n;
  always #5 ref_clk = ~ref_clk;
  flash_write_control_sequencer i_flash_write_control_sequencer (.ref_clk, .nrst, .reg_rd,
    .reg_wr, .reg_addr, .reg_be(2'h3), .reg_wdata, .reg_rdata, .reg_trap, .bank_rd, .bank_wr,
    .bank_rd_trap, .bank_wr_allow, .bootstrap_mode, .test_sector_wr, .test_sector_visible(),
    .test_write_deny(), .arr_req, .arr_cmd, .arr_addr, .arr_sector, .arr_wdata, .arr_rdata,
    .arr_ack);
  flash_array_model i_flash_array_model (.ref_clk, .arr_req, .arr_cmd, .arr_addr, .arr_sector,
    .arr_wdata, .slow, .arr_rdata, .arr_ack);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(string s, logic [31:0] x, logic [31:0] y);
    cmp_count++;
    if (y !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask : chk
  task automatic wr(logic [23:0] ad, logic [15:0] dt);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = dt;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [23:0] ad);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = ad;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    rv = {reg_trap, reg_rdata};
  endtask : rd
  task automatic rdc(string s, logic [23:0] ad, logic [16:0] x);
    rd(ad);
    chk(s, 32'(x), 32'(rv));
  endtask : rdc
  task automatic idle();
    n = 0;
    do begin
      rd(ADDR_CTRL_LOW);
      n++;
    end while (rv[BIT_LOCK] !== 1'b0 && n < 400);
    chk("lock", 32'h0, 32'(rv[BIT_LOCK]));
  endtask : idle
  task automatic prog(logic [23:0] ad, logic [31:0] x, logic [31:0] y, logic [15:0] op);
    wr(ADDR_TGT_LOW, ad[15:0]);
    wr(ADDR_TGT_HIGH, {8'h00, ad[23:16]});
    wr(ADDR_DATA0_LOW, x[15:0]);
    wr(ADDR_DATA0_HIGH, x[31:16]);
    wr(ADDR_DATA1_LOW, y[15:0]);
    wr(ADDR_DATA1_HIGH, y[31:16]);
    wr(ADDR_CTRL_HIGH, op);
  endtask : prog
  function automatic logic [31:0] andw(logic [31:0] o, logic [31:0] w);
    return o & w;
  endfunction : andw
  always @(negedge ref_clk) begin
    if (nrst) begin
      bank_rd = 2'($urandom);
      bank_wr = 2'($urandom);
      test_sector_wr = 1'($urandom);
      bootstrap_mode = 1'($urandom);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end
  initial begin
    n = $urandom(69);
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    rdc("status", ADDR_CTRL_LOW, 17'h00000);
    rdc("operation", ADDR_CTRL_HIGH, 17'h00000);
    $display("reset test done");
    slow = 1'b1;
    b = BANK1_BASE | (24'($urandom) & 24'h00FFFC);
    d = $urandom;
    e = $urandom;
    prog(b, d, e, 16'hA001);
    rdc("busy", ADDR_CTRL_LOW, 17'h00050);
    rdc("locked", ADDR_DATA0_LOW, 17'h1FFFF);
    wr(ADDR_DATA0_LOW, 16'h0000);
    idle();
    rdc("op end", ADDR_CTRL_HIGH, 17'h00000);
    rdc("data kept", ADDR_DATA0_LOW, {1'b0, d[15:0]});
    slow = 1'b0;
    prog(b, e, d, 16'hA001);
    idle();
    chk("word", andw(d, e), i_flash_array_model.mem[b]);
    a = 24'h010000 | (24'($urandom) & 24'h00FFF8);
    prog(a, d, e, 16'h9001);
    idle();
    chk("even", d, i_flash_array_model.mem[a]);
    chk("odd", e, i_flash_array_model.mem[a + 24'h4]);
    rdc("dword end", ADDR_CTRL_HIGH, 17'h00000);
    $display("program test done");
    prog(PROT_HIGH + 24'h1, d, e, 16'h8100);
    idle();
    rdc("seq error", ADDR_ERR, 17'h00003);
    wr(ADDR_CTRL_HIGH, 16'hA001);
    rdc("refused", ADDR_CTRL_LOW, 17'h00000);
    wr(ADDR_ERR, 16'h0000);
    wr(ADDR_CTRL_HIGH, 16'h0000);
    slow = 1'b1;
    prog(PROT_LOW, d, e, 16'h8100);
    rdc("prot busy", ADDR_CTRL_LOW, 17'h00070);
    idle();
    rdc("prot end", ADDR_CTRL_HIGH, 17'h00000);
    rdc("no error", ADDR_ERR, 17'h00000);
    prog(24'h000100, d, e, 16'hA001);
    idle();
    rdc("test sector", ADDR_ERR, 17'h00003);
    wr(ADDR_ERR, 16'h0000);
    $display("protection test done");
    wr(ADDR_SECT_HIGH, 16'h0001);
    wr(ADDR_CTRL_HIGH, 16'h8801);
    idle();
    chk("erased", ERASED_WORD, i_flash_array_model.mem[b]);
    rdc("erase end", ADDR_CTRL_HIGH, 17'h00000);
    prog(b, d, e, 16'hA001);
    wr(ADDR_CTRL_HIGH, 16'h6001);
    rd(ADDR_CTRL_LOW);
    chk("suspended", 32'h0, 32'(rv[6:5]));
    wr(ADDR_CTRL_HIGH, 16'h2001);
    wr(ADDR_CTRL_HIGH, 16'hA001);
    rd(ADDR_CTRL_LOW);
    chk("resumed", 32'h2, 32'(rv[6:5]));
    idle();
    chk("resumed word", andw(ERASED_WORD, d), i_flash_array_model.mem[b]);
    $display("erase and suspend test done");
    end_of_test();
  end
endmodule : testbench
bind flash_write_control_sequencer flash_seq_asserts i_flash_seq_asserts (.ref_clk, .nrst,
  .reg_rd, .reg_addr, .reg_rdata, .reg_trap, .bank_rd, .bank_rd_trap, .bank_wr,
  .bank_wr_allow, .bootstrap_mode, .test_sector_wr, .test_write_deny, .test_sector_visible,
  .arr_req, .arr_cmd,
  .arr_addr, .arr_wdata);
`default_nettype wire
